// *** src/als_pkg.sv ***
package als_pkg;
  // clock and time base
  localparam int CLK_HZ = 25_000_000;
  localparam int SEC_TIME_S = 1;
  localparam int SEC_CYCLES = CLK_HZ * SEC_TIME_S;
  localparam int SEC_PER_MIN = 60;
  localparam int MIN_PER_HOUR = 60;
  localparam int JAM_TIME_MIN = 3;
  localparam int JAM_TIME_S = JAM_TIME_MIN * SEC_PER_MIN;
  localparam int ENTRY_TIME_S = 25;
  localparam int STATUS_PERIOD_MIN = 1 * MIN_PER_HOUR;
  localparam int BURST_WINDOW_MIN = 6;
  // link message layout: type in the top two bits, sensor id or digit below
  localparam int MSG_BITS = 8;
  localparam int ID_W = 6;
  localparam int DIGIT_W = 4;
  localparam int CODE_DIGITS = 4;
  localparam int NUM_WORDS = 10;
  localparam logic [1:0] AGE_INIT = 2'h2;
  localparam logic [1:0] MISS_LIMIT = 2'h2;
  typedef enum logic [1:0] {
    MSG_CODE = 2'h0,
    MSG_ALARM = 2'h1,
    MSG_SECURE = 2'h2,
    MSG_STATUS = 2'h3
  } als_msg_t;
  // system state, one-hot
  typedef enum logic [2:0] {
    ST_DISARMED = 3'h1,
    ST_ARMED = 3'h2,
    ST_ENTRY = 3'h4
  } als_state_t;
  // sensor mode selections
  localparam logic [1:0] SMODE_NONE = 2'h0;
  localparam logic [1:0] SMODE_PERIM = 2'h1;
  // display codes for non-sensor events, in BCD
  localparam logic [7:0] CODE_TAMPER = 8'h97;
  localparam logic [7:0] CODE_ENTRY = 8'h98;
  localparam logic [7:0] CODE_JAM = 8'h99;
  // register byte offsets
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_MODE = 12'h004;
  localparam logic [11:0] REG_PRUNE = 12'h008;
  localparam logic [11:0] REG_PERIM = 12'h00C;
  localparam logic [11:0] REG_COMBO = 12'h010;
  localparam logic [11:0] REG_KEY = 12'h014;
  localparam logic [11:0] REG_PANEL = 12'h018;
  localparam logic [11:0] REG_ENTRY = 12'h01C;
  localparam logic [11:0] REG_STATUS = 12'h020;
  localparam logic [11:0] REG_EVENT = 12'h024;
  localparam logic [11:0] REG_SWSEL = 12'h028;
  localparam logic [11:0] REG_SWDATA = 12'h02C;
  // field positions
  localparam int CTRL_ARM = 0;
  localparam int CTRL_FLAGS_LSB = 4;
  localparam int MODE_AMODE_LSB = 2;
  localparam int ST_ARMED_BIT = 0;
  localparam int ST_ALARM_BIT = 1;
  localparam int ST_TROUBLE_BIT = 2;
  localparam int ST_BYPASS_BIT = 3;
  localparam int ST_ALERT_BIT = 4;
  localparam int ST_FLASH_BIT = 5;
  localparam int ST_JAM_BIT = 6;
  localparam int EV_TROUBLE_LSB = 8;
  // synchronised pin bundle positions
  localparam int PIN_RX_CLK = 0;
  localparam int PIN_RX_DATA = 1;
  localparam int PIN_FRAME = 2;
  localparam int PIN_LOCK = 3;
  localparam int PIN_TAMP_LSB = 4;
  localparam int PIN_DOOR = 7;
  localparam int PIN_EC = 8;
  localparam int PIN_BTN = 9;
  localparam int PIN_SW_LSB = 10;
  localparam int PIN_W = 18;
endpackage

// *** src/als_tmr_if.sv ***
`timescale 1ns/1ps
interface als_tmr_if;
  logic run;
  logic tick;
  logic done;
  modport owner (output run, output tick, input done);
  modport timer (input run, input tick, output done);
endinterface

// *** src/als_timer.sv ***
`timescale 1ns/1ps
// counts ticks while run is high; periodic mode pulses done every LIMIT ticks,
// one-shot mode raises done after more than LIMIT ticks and holds it while run
module als_timer #(
  parameter int LIMIT = 60,
  parameter bit PERIODIC = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  als_tmr_if.timer t
);
  localparam int W = $clog2(LIMIT + 1);
  logic [W-1:0] count;
  logic done_q;

  // tick counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
      done_q <= 1'b0;
    end else if (!t.run) begin
      count <= '0;
      done_q <= 1'b0;
    end else if (PERIODIC) begin
      done_q <= 1'b0;
      if (t.tick) begin
        if (count == W'(LIMIT - 1)) begin
          count <= '0;
          done_q <= 1'b1;
        end else begin
          count <= count + W'(1);
        end
      end
    end else if (t.tick && !done_q) begin
      if (count == W'(LIMIT)) begin
        done_q <= 1'b1;
      end else begin
        count <= count + W'(1);
      end
    end
  end

  assign t.done = done_q;
endmodule

// *** src/als_top.sv ***
`timescale 1ns/1ps
// Summary of operation
// (RULE_01) armed sensors are judged by sensor mode and pruning mask
// (RULE_02) a sensor sends each alarm message five times a minute apart
// (RULE_03) a sensor sends each secure message five times a minute apart
// (RULE_04) lock indicator held for three minutes or more raises an alarm; the code needs it held for more than 180 second ticks
// (RULE_05) a secure message with no alarm before it raises an alarm
// (RULE_06) every sensor sends one status message each hour
// (RULE_07) trouble is declared after two missed hourly status messages
// (RULE_08) pulling a sensor's mounting screw makes it send alarm messages
// (RULE_09) any tamper switch raises an alarm, armed or not
// (RULE_10) panel code then open door bypasses tampers until door closes
// (RULE_11) correct encrypted entrance code disarms and releases the strike
// (RULE_12) alarm or trouble while armed makes the keyboard light flash
// (RULE_13) trouble button after an alarm flashes the alarmed sensor number
// (RULE_14) trouble shows steadily: sensor number or a jamming code
// (RULE_15) no entrance control: entry alert, alarm unless panel code in 25 s; the code raises it after more than 25 second ticks
// (RULE_16) one input port shows one of ten selectable switch words
// (RULE_17) link messages arrive serially one bit at a time
// (RULE_18) output port one carries BCD digits for the trouble display
// (RULE_19) output port two drives the alarm and sensor mode LEDs
// (RULE_20) output port three drives lights, alert, alarm and link flags
// (RULE_21) repeated copies of one message within a burst count once
module als_top #(
  parameter int NUM_SENSORS = 16,
  parameter int SEC_CYCLES = als_pkg::SEC_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_clk,
  input wire logic rx_data,
  input wire logic rx_frame,
  input wire logic rx_lock,
  input wire logic [2:0] tamper,
  input wire logic door_open,
  input wire logic ec_present,
  input wire logic trouble_btn,
  input wire logic [7:0] sw_data,
  output logic [3:0] sw_sel,
  output logic [7:0] disp_bcd,
  output logic disp_on,
  output logic [7:0] mode_leds,
  output logic [7:0] port3,
  output logic ec_strike,
  output logic ec_flash
);
  // pin synchroniser: three stages, a change counts once stages two and three agree
  logic [als_pkg::PIN_W-1:0] pin_raw, s1, s2, s3, pins, pins_q;
  assign pin_raw = {sw_data, trouble_btn, ec_present, door_open, tamper, rx_lock, rx_frame,
                    rx_data, rx_clk};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      pins <= '0;
      pins_q <= '0;
    end else begin
      s1 <= pin_raw;
      s2 <= s1;
      s3 <= s2;
      pins <= (s2 & ~(s2 ^ s3)) | (pins & (s2 ^ s3));
      pins_q <= pins;
    end
  end

  logic frame, lock, door, ec_on, btn, clk_rise;
  logic [2:0] tamp, tamp_q;
  assign frame = pins[als_pkg::PIN_FRAME];
  assign lock = pins[als_pkg::PIN_LOCK];
  assign door = pins[als_pkg::PIN_DOOR];
  assign ec_on = pins[als_pkg::PIN_EC];
  assign btn = pins[als_pkg::PIN_BTN];
  assign tamp = pins[als_pkg::PIN_TAMP_LSB +: 3];
  assign tamp_q = pins_q[als_pkg::PIN_TAMP_LSB +: 3];
  assign clk_rise = pins[als_pkg::PIN_RX_CLK] & ~pins_q[als_pkg::PIN_RX_CLK];

  // time base: seconds, minutes, burst window, hour, jam and entry timers
  als_tmr_if sec_if();
  als_tmr_if min_if();
  als_tmr_if burst_if();
  als_tmr_if hour_if();
  als_tmr_if jam_if();
  als_tmr_if entry_if();
  als_pkg::als_state_t state;
  assign sec_if.run = 1'b1;
  assign sec_if.tick = 1'b1;
  assign min_if.run = 1'b1;
  assign min_if.tick = sec_if.done;
  assign burst_if.run = 1'b1;
  assign burst_if.tick = min_if.done;
  assign hour_if.run = 1'b1;
  assign hour_if.tick = min_if.done;
  assign jam_if.run = lock;
  assign jam_if.tick = sec_if.done;
  assign entry_if.run = (state == als_pkg::ST_ENTRY);
  assign entry_if.tick = sec_if.done;
  als_timer #(.LIMIT(SEC_CYCLES), .PERIODIC(1'b1)) u_sec (
    .pclk(pclk), .presetn(presetn), .t(sec_if));
  als_timer #(.LIMIT(als_pkg::SEC_PER_MIN), .PERIODIC(1'b1)) u_min (
    .pclk(pclk), .presetn(presetn), .t(min_if));
  als_timer #(.LIMIT(als_pkg::BURST_WINDOW_MIN), .PERIODIC(1'b1)) u_burst (
    .pclk(pclk), .presetn(presetn), .t(burst_if));
  als_timer #(.LIMIT(als_pkg::STATUS_PERIOD_MIN), .PERIODIC(1'b1)) u_hour (
    .pclk(pclk), .presetn(presetn), .t(hour_if));
  // (RULE_04) jam hold timer
  als_timer #(.LIMIT(als_pkg::JAM_TIME_S), .PERIODIC(1'b0)) u_jam (
    .pclk(pclk), .presetn(presetn), .t(jam_if));
  // (RULE_15) entry delay timer
  als_timer #(.LIMIT(als_pkg::ENTRY_TIME_S), .PERIODIC(1'b0)) u_entry (
    .pclk(pclk), .presetn(presetn), .t(entry_if));

  // apb decode
  logic wr, rd_setup, hit;
  assign wr = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign pready = 1'b1;
  always_comb begin
    unique case (paddr)
      als_pkg::REG_CTRL, als_pkg::REG_MODE, als_pkg::REG_PRUNE, als_pkg::REG_PERIM,
      als_pkg::REG_COMBO, als_pkg::REG_KEY, als_pkg::REG_PANEL, als_pkg::REG_ENTRY,
      als_pkg::REG_STATUS, als_pkg::REG_EVENT, als_pkg::REG_SWSEL,
      als_pkg::REG_SWDATA: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end
  assign pslverr = psel & penable & ~hit;

  // software registers
  logic [3:0] flags;
  logic [1:0] smode, amode;
  logic [NUM_SENSORS-1:0] prune, perim;
  logic [15:0] combo;
  logic [7:0] key;
  logic [als_pkg::ID_W-1:0] entry_id;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= '0;
      smode <= '0;
      amode <= '0;
      prune <= '0;
      perim <= '0;
      combo <= '0;
      key <= '0;
      entry_id <= '0;
      sw_sel <= '0;
    end else if (wr) begin
      if (paddr == als_pkg::REG_CTRL) flags <= pwdata[als_pkg::CTRL_FLAGS_LSB +: 4];
      if (paddr == als_pkg::REG_MODE) begin
        smode <= pwdata[1:0];
        amode <= pwdata[als_pkg::MODE_AMODE_LSB +: 2];
      end
      if (paddr == als_pkg::REG_PRUNE) prune <= pwdata[NUM_SENSORS-1:0];
      if (paddr == als_pkg::REG_PERIM) perim <= pwdata[NUM_SENSORS-1:0];
      if (paddr == als_pkg::REG_COMBO) combo <= pwdata[15:0];
      if (paddr == als_pkg::REG_KEY) key <= pwdata[7:0];
      if (paddr == als_pkg::REG_ENTRY) entry_id <= pwdata[als_pkg::ID_W-1:0];
      // (RULE_16) word select writes past the ten words are ignored
      if (paddr == als_pkg::REG_SWSEL && pwdata[3:0] < 4'(als_pkg::NUM_WORDS))
        sw_sel <= pwdata[3:0];
    end
  end

  // (RULE_17) serial message assembly on recovered clock edges
  logic [als_pkg::MSG_BITS-1:0] shreg;
  logic [3:0] bit_cnt;
  logic msg_valid;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shreg <= '0;
      bit_cnt <= '0;
      msg_valid <= 1'b0;
    end else begin
      msg_valid <= frame & clk_rise & (bit_cnt == 4'(als_pkg::MSG_BITS - 1));
      if (!frame) begin
        bit_cnt <= '0;
      end else if (clk_rise && bit_cnt != 4'(als_pkg::MSG_BITS)) begin
        shreg <= {shreg[als_pkg::MSG_BITS-2:0], pins[als_pkg::PIN_RX_DATA]};
        bit_cnt <= bit_cnt + 4'h1;
      end
    end
  end
  logic [1:0] msg_type;
  logic [als_pkg::ID_W-1:0] msg_id;
  logic is_sensor, is_code;
  assign msg_type = shreg[als_pkg::MSG_BITS-1 -: 2];
  assign msg_id = shreg[als_pkg::ID_W-1:0];
  assign is_code = msg_valid & (msg_type == als_pkg::MSG_CODE);
  assign is_sensor = msg_valid & ~is_code & (int'(msg_id) < NUM_SENSORS);

  // (RULE_11) encrypted digits decoded with either key alternation
  logic [15:0] ec_hist, pn_hist, key_a, key_b;
  logic [2:0] ec_cnt, pn_cnt;
  logic ec_match, pn_match, pn_wr;
  assign key_a = {key, key};
  assign key_b = {key[3:0], key[7:4], key[3:0], key[7:4]};
  assign pn_wr = wr & (paddr == als_pkg::REG_PANEL);
  assign ec_match = (ec_cnt == 3'(als_pkg::CODE_DIGITS)) &
                    (((ec_hist ^ key_a) == combo) | ((ec_hist ^ key_b) == combo));
  assign pn_match = (pn_cnt == 3'(als_pkg::CODE_DIGITS)) & (pn_hist == combo);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ec_hist <= '0;
      ec_cnt <= '0;
      pn_hist <= '0;
      pn_cnt <= '0;
    end else begin
      if (ec_match) begin
        ec_cnt <= '0;
      end else if (is_code) begin
        ec_hist <= {ec_hist[11:0], shreg[als_pkg::DIGIT_W-1:0]};
        if (ec_cnt != 3'(als_pkg::CODE_DIGITS)) ec_cnt <= ec_cnt + 3'h1;
      end
      if (pn_match) begin
        pn_cnt <= '0;
      end else if (pn_wr) begin
        pn_hist <= {pn_hist[11:0], pwdata[als_pkg::DIGIT_W-1:0]};
        if (pn_cnt != 3'(als_pkg::CODE_DIGITS)) pn_cnt <= pn_cnt + 3'h1;
      end
    end
  end

  // per-sensor table lookup and status scan
  logic [1:0] last_type [NUM_SENSORS];
  logic [1:0] age [NUM_SENSORS];
  logic [1:0] missed [NUM_SENSORS];
  logic [NUM_SENSORS-1:0] seen, mon_mask;
  logic dup, was_alarm, mon, miss_hit;
  logic [als_pkg::ID_W-1:0] miss_id;
  localparam logic [1:0] MISS_LIMIT_M1 = als_pkg::MISS_LIMIT - 2'h1;
  // (RULE_01) mode and pruning select monitored sensors
  assign mon_mask = prune & ((smode == als_pkg::SMODE_PERIM) ? perim :
                    (smode == als_pkg::SMODE_NONE) ? '0 : '1);
  always_comb begin
    dup = 1'b0;
    was_alarm = 1'b0;
    mon = 1'b0;
    miss_hit = 1'b0;
    miss_id = '0;
    for (int s = 0; s < NUM_SENSORS; s++) begin
      if (is_sensor && msg_id == als_pkg::ID_W'(s)) begin
        // (RULE_21) same type inside burst window
        dup = (age[s] != 2'h0) && (last_type[s] == msg_type);
        was_alarm = (last_type[s] == als_pkg::MSG_ALARM);
        mon = mon_mask[s];
      end
      // (RULE_07) second missed status
      if (hour_if.done && !seen[s] && missed[s] == MISS_LIMIT_M1 && !miss_hit) begin
        miss_hit = 1'b1;
        miss_id = als_pkg::ID_W'(s);
      end
    end
  end

  // per-sensor table update; a new message wins over ageing in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen <= '0;
      for (int s = 0; s < NUM_SENSORS; s++) begin
        last_type[s] <= als_pkg::MSG_SECURE;
        age[s] <= '0;
        missed[s] <= '0;
      end
    end else begin
      for (int s = 0; s < NUM_SENSORS; s++) begin
        // (RULE_02) burst copies age out after the window
        if (burst_if.done && age[s] != 2'h0) age[s] <= age[s] - 2'h1;
        // (RULE_06) hourly status bookkeeping
        if (hour_if.done) begin
          seen[s] <= 1'b0;
          if (!seen[s] && missed[s] != als_pkg::MISS_LIMIT) missed[s] <= missed[s] + 2'h1;
        end
        if (is_sensor && msg_id == als_pkg::ID_W'(s)) begin
          // (RULE_03) each copy restarts the window
          age[s] <= als_pkg::AGE_INIT;
          if (!dup) last_type[s] <= msg_type;
          if (msg_type == als_pkg::MSG_STATUS) begin
            seen[s] <= 1'b1;
            missed[s] <= '0;
          end
        end
      end
    end
  end

  // alarm sources
  logic armed, sensor_alarm, entry_start, orphan, tamper_alarm, jam_alarm, jam_q;
  logic entry_fail, alarm_ev, bypass, panel_ok;
  assign armed = (state != als_pkg::ST_DISARMED);
  assign sensor_alarm = is_sensor & ~dup & mon & armed & (msg_type == als_pkg::MSG_ALARM);
  // (RULE_15) entry sensor starts the delay when no entrance control
  assign entry_start = sensor_alarm & ~ec_on & (msg_id == entry_id) &
                       (state == als_pkg::ST_ARMED);
  // (RULE_05) orphan secure alarm
  assign orphan = is_sensor & ~dup & mon & armed & (msg_type == als_pkg::MSG_SECURE) &
                  ~was_alarm;
  // (RULE_09) tamper edge alarm
  assign tamper_alarm = |(tamp & ~tamp_q) & ~bypass;
  // (RULE_04) jam alarm on first expiry
  assign jam_alarm = jam_if.done & ~jam_q;
  assign entry_fail = (state == als_pkg::ST_ENTRY) & entry_if.done;
  assign alarm_ev = (sensor_alarm & ~entry_start) | orphan | tamper_alarm | jam_alarm |
                    entry_fail;

  function automatic logic [7:0] to_bcd(input logic [als_pkg::ID_W-1:0] v);
    logic [als_pkg::ID_W-1:0] tens;
    logic [als_pkg::ID_W-1:0] units;
    tens = v / als_pkg::ID_W'(10);
    units = v % als_pkg::ID_W'(10);
    return {tens[3:0], units[3:0]};
  endfunction

  // (RULE_10) tamper bypass after panel code and door open
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      panel_ok <= 1'b0;
      bypass <= 1'b0;
    end else begin
      if (!door) begin
        bypass <= 1'b0;
        if (bypass) panel_ok <= 1'b0;
      end else if (panel_ok) begin
        bypass <= 1'b1;
      end
      if (pn_match && !door) panel_ok <= 1'b1;
    end
  end

  // system state machine
  logic disarm, arm_req, sw_disarm;
  assign arm_req = wr & (paddr == als_pkg::REG_CTRL) & pwdata[als_pkg::CTRL_ARM];
  assign sw_disarm = wr & (paddr == als_pkg::REG_CTRL) & ~pwdata[als_pkg::CTRL_ARM];
  assign disarm = armed & (ec_match | pn_match | sw_disarm);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= als_pkg::ST_DISARMED;
    end else begin
      unique case (state)
        als_pkg::ST_DISARMED: if (arm_req) state <= als_pkg::ST_ARMED;
        als_pkg::ST_ARMED: begin
          if (disarm) state <= als_pkg::ST_DISARMED;
          else if (entry_start) state <= als_pkg::ST_ENTRY;
        end
        als_pkg::ST_ENTRY: begin
          if (disarm) state <= als_pkg::ST_DISARMED;
          else if (entry_fail) state <= als_pkg::ST_ARMED;
        end
        default: state <= als_pkg::ST_DISARMED;
      endcase
    end
  end

  // alarm, trouble and flash flags; set wins over a software clear
  logic alarm, trouble, armed_ev;
  logic [7:0] alarm_code, trouble_code;
  logic clr_wr;
  assign clr_wr = wr & (paddr == als_pkg::REG_STATUS);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm <= 1'b0;
      trouble <= 1'b0;
      armed_ev <= 1'b0;
      alarm_code <= '0;
      trouble_code <= '0;
      ec_flash <= 1'b0;
      ec_strike <= 1'b0;
      jam_q <= 1'b0;
    end else begin
      jam_q <= jam_if.done;
      // (RULE_11) strike release pulse
      ec_strike <= ec_match;
      if (clr_wr && pwdata[als_pkg::ST_ALARM_BIT]) alarm <= 1'b0;
      if (clr_wr && pwdata[als_pkg::ST_TROUBLE_BIT]) trouble <= 1'b0;
      if (clr_wr && pwdata[als_pkg::ST_FLASH_BIT]) ec_flash <= 1'b0;
      if (arm_req && !armed) begin
        armed_ev <= 1'b0;
        ec_flash <= 1'b0;
      end
      if (alarm_ev) begin
        alarm <= 1'b1;
        if (!alarm) alarm_code <= tamper_alarm ? als_pkg::CODE_TAMPER :
                                  jam_alarm ? als_pkg::CODE_JAM :
                                  entry_fail ? als_pkg::CODE_ENTRY : to_bcd(msg_id);
      end
      // (RULE_14) trouble code: sensor number or jamming
      if (miss_hit || jam_alarm) begin
        trouble <= 1'b1;
        trouble_code <= jam_alarm ? als_pkg::CODE_JAM : to_bcd(miss_id);
      end
      if ((alarm_ev || miss_hit || jam_alarm) && armed) armed_ev <= 1'b1;
      // (RULE_12) keyboard flash on disarm
      if (disarm && (armed_ev || alarm_ev || miss_hit)) ec_flash <= 1'b1;
    end
  end

  // output ports and display
  logic blink;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blink <= 1'b0;
      disp_bcd <= '0;
      disp_on <= 1'b0;
      mode_leds <= '0;
      port3 <= '0;
    end else begin
      if (sec_if.done) blink <= ~blink;
      // (RULE_18) BCD to display port
      disp_bcd <= alarm ? alarm_code : trouble_code;
      // (RULE_13) flashing alarm, steady trouble
      disp_on <= btn & (alarm ? blink : trouble);
      // (RULE_19) mode LEDs one-hot
      mode_leds <= {4'(4'h1 << amode), 4'(4'h1 << smode)};
      // (RULE_20) lights, alert, alarm and link flags
      port3 <= {flags, alarm, (state == als_pkg::ST_ENTRY), bypass, armed};
    end
  end

  // apb read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (rd_setup) begin
      prdata <= '0;
      unique case (paddr)
        als_pkg::REG_CTRL: prdata <= 32'({flags, 3'h0, armed});
        als_pkg::REG_MODE: prdata <= 32'({amode, smode});
        als_pkg::REG_PRUNE: prdata <= 32'(prune);
        als_pkg::REG_PERIM: prdata <= 32'(perim);
        als_pkg::REG_COMBO: prdata <= 32'(combo);
        als_pkg::REG_KEY: prdata <= 32'(key);
        als_pkg::REG_ENTRY: prdata <= 32'(entry_id);
        als_pkg::REG_STATUS: prdata <= 32'({jam_if.done, ec_flash,
                              (state == als_pkg::ST_ENTRY), bypass, trouble, alarm, armed});
        als_pkg::REG_EVENT: prdata <= 32'({trouble_code, alarm_code});
        als_pkg::REG_SWSEL: prdata <= 32'(sw_sel);
        // (RULE_16) selected switch word
        als_pkg::REG_SWDATA: prdata <= 32'(pins[als_pkg::PIN_SW_LSB +: 8]);
        default: prdata <= '0;
      endcase
    end
  end
endmodule

// *** test/als_chk.sv ***
`timescale 1ns/1ps
// port-level checks on the supervisor outputs
module als_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [2:0] tamper,
  input wire logic trouble_btn,
  input wire logic [3:0] sw_sel,
  input wire logic [7:0] disp_bcd,
  input wire logic disp_on,
  input wire logic [7:0] mode_leds,
  input wire logic [7:0] port3,
  input wire logic ec_strike
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_high: assert property (pready) else $error("pready low");
  a_err_access: assert property (pslverr |-> psel && penable) else $error("stray slverr");
  a_strike_pulse: assert property (ec_strike |=> !ec_strike) else $error("strike too long");
  a_strike_disarms: assert property (ec_strike |-> ##[0:2] !port3[0])
    else $error("armed after strike");
  a_tamper_alarm: assert property ($rose(tamper[0]) && !port3[1] |-> ##[1:12] port3[3])
    else $error("no alarm on tamper");
  a_sel_range: assert property (sw_sel <= 4'h9) else $error("word select out of range");
  a_disp_btn: assert property (!trouble_btn [*8] |=> !disp_on) else $error("display lit");
  a_disp_bcd: assert property (disp_on |-> disp_bcd[7:4] <= 4'h9 && disp_bcd[3:0] <= 4'h9)
    else $error("display not bcd");
  a_led_onehot: assert property ($onehot0(mode_leds[7:4]) && $onehot0(mode_leds[3:0]))
    else $error("mode leds not one-hot");
  c_strike: cover property (ec_strike);
  c_slverr: cover property (pslverr);
  c_disp: cover property (disp_on);
endmodule
bind als_top als_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .tamper(tamper), .trouble_btn(trouble_btn),
  .sw_sel(sw_sel), .disp_bcd(disp_bcd), .disp_on(disp_on), .mode_leds(mode_leds),
  .port3(port3), .ec_strike(ec_strike));

// *** test/als_link_model.sv ***
`timescale 1ns/1ps
// remote transmitter on the message link; clock stands still between frames
module als_link_model (
  input wire logic pclk,
  output logic rx_clk,
  output logic rx_data,
  output logic rx_frame
);
  initial begin
    rx_clk = 1'b0;
    rx_data = 1'b0;
    rx_frame = 1'b0;
  end
  // link message copy, sensor message or code digit
  // one framed byte, six cycles per clock level
  task automatic send(input logic [7:0] b);
    rx_frame <= 1'b1;
    repeat (6) @(posedge pclk);
    for (int i = 7; i >= 0; i--) begin
      rx_data <= b[i];
      repeat (6) @(posedge pclk);
      rx_clk <= 1'b1;
      repeat (6) @(posedge pclk);
      rx_clk <= 1'b0;
    end
    repeat (6) @(posedge pclk);
    rx_frame <= 1'b0;
    rx_data <= ~b[0];
    repeat (12) @(posedge pclk);
  endtask
endmodule

// *** test/alarm_supervisor_tb_top.sv ***
`timescale 1ns/1ps
module alarm_supervisor_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr, strike_seen;
  logic rx_clk, rx_data, rx_frame, rx_lock, door_open, ec_present, trouble_btn;
  logic disp_on, ec_strike, ec_flash;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [2:0] tamper;
  logic [7:0] sw_data, disp_bcd, mode_leds, port3;
  logic [3:0] sw_sel;
  logic [3:0] code [4] = '{4'hB, 4'h7, 4'h9, 4'h1};
  int err_count, comparisons;
  als_top #(.NUM_SENSORS(16), .SEC_CYCLES(20)) u_als_top (.*);
  als_link_model u_als_link_model (.*);
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // remember any strike pulse
  always @(posedge pclk) if (ec_strike === 1'b1) strike_seen <= 1'b1;
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (8000) @(posedge pclk);
    err_count++;
    report_and_stop;
  end
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
    pwdata = 32'h0; rx_lock = 1'b0; door_open = 1'b0; ec_present = 1'b1;
    trouble_btn = 1'b0; tamper = 3'h0; sw_data = 8'hA5; strike_seen = 1'b0;
    err_count = 0;
    comparisons = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
    apb(1'b0, als_pkg::REG_STATUS, 32'h0);
    chk("status", 32'h0, rdat);
    apb(1'b0, 12'h030, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, rerr});
    $display("test reset done");
    apb(1'b1, als_pkg::REG_MODE, 32'h2);
    apb(1'b1, als_pkg::REG_PRUNE, 32'hFFFF);
    apb(1'b1, als_pkg::REG_KEY, 32'h5A);
    apb(1'b1, als_pkg::REG_COMBO, 32'h1234);
    apb(1'b1, als_pkg::REG_CTRL, 32'h1);
    u_als_link_model.send(8'h83);
    apb(1'b0, als_pkg::REG_STATUS, 32'h0);
    chk("status", 32'h3, rdat);
    apb(1'b0, als_pkg::REG_EVENT, 32'h0);
    chk("event", 32'h3, rdat);
    chk("mode leds", 32'h14, {24'h0, mode_leds});
    chk("port3", 32'h9, {24'h0, port3});
    apb(1'b1, als_pkg::REG_STATUS, 32'h2);
    u_als_link_model.send(8'h83);
    apb(1'b0, als_pkg::REG_STATUS, 32'h0);
    chk("repeat copy", 32'h1, rdat);
    foreach (code[i]) u_als_link_model.send({4'h0, code[i]});
    chk("strike", 32'h1, {31'h0, strike_seen});
    apb(1'b0, als_pkg::REG_STATUS, 32'h0);
    chk("status", 32'h20, rdat);
    $display("test code disarm done");
    apb(1'b1, als_pkg::REG_STATUS, 32'h26);
    tamper <= 3'h1;
    repeat (12) @(posedge pclk);
    apb(1'b0, als_pkg::REG_EVENT, 32'h0);
    chk("event", 32'h97, rdat);
    tamper <= 3'h0;
    trouble_btn <= 1'b1;
    repeat (10) @(posedge pclk);
    chk("display", 32'h97, {24'h0, disp_bcd});
    rdat = {31'h0, disp_on};
    repeat (20) @(posedge pclk);
    chk("flash", rdat ^ 32'h1, {31'h0, disp_on});
    trouble_btn <= 1'b0;
    apb(1'b1, als_pkg::REG_STATUS, 32'h26);
    $display("test tamper done");
    rx_lock <= 1'b1;
    repeat (3500) @(posedge pclk);
    apb(1'b0, als_pkg::REG_STATUS, 32'h0);
    chk("early jam", 32'h0, rdat);
    repeat (150) @(posedge pclk);
    apb(1'b0, als_pkg::REG_STATUS, 32'h0);
    chk("jam status", 32'h46, rdat);
    apb(1'b0, als_pkg::REG_EVENT, 32'h0);
    chk("trouble code", 32'h99, (rdat >> 8) & 32'hFF);
    rx_lock <= 1'b0;
    $display("test jam done");
    apb(1'b1, als_pkg::REG_SWSEL, 32'h9);
    apb(1'b1, als_pkg::REG_SWSEL, 32'hA);
    chk("word select", 32'h9, {28'h0, sw_sel});
    apb(1'b0, als_pkg::REG_SWDATA, 32'h0);
    chk("switch word", 32'hA5, rdat);
    $display("test switch port done");
    report_and_stop;
  end
endmodule
